// ---- tdm_router_pkg.sv ----
// Constants shared by the TDM slot router and its testbench.
// Assumes a single 10 MHz system clock and an AXI4-Lite register port.
package tdm_router_pkg;

    // Serial frame geometry
    localparam int SLOT_BITS    = 32;
    localparam int SAMPLE_BITS  = 24;
    localparam int PAD_BITS     = SLOT_BITS - SAMPLE_BITS;
    localparam int TRK_BYTE     = 8;
    localparam int CHANNELS     = 4;
    localparam int CNT_W        = 9;
    localparam logic [CNT_W-1:0] LAST_TDM = 9'h1FF;
    localparam logic [CNT_W-1:0] LAST_PCM = 9'h03F;
    localparam logic [CNT_W-1:0] I2S_PRE  = 9'h1FF;
    localparam logic [3:0] SLOT_LAST_TDM  = 4'hF;
    localparam logic [3:0] SLOT_LAST_PCM  = 4'h1;
    localparam logic [3:0] ADC_SLOTS      = 4'h4;
    localparam logic [4:0] BIT_LAST       = 5'h1F;
    localparam logic [4:0] PAD_FIRST      = 5'h18;

    // Register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DSEL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_GDLY = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h0C;

    // Field positions
    localparam int CHAIN_BIT = 0;
    localparam int TRK_LSB   = 1;
    localparam int FMT_LSB   = 4;
    localparam int DAC_LSB   = 0;
    localparam int LL_LSB    = 4;
    localparam int GD_LSB    = 0;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DSEL_RST = 8'h00;
    localparam logic [7:0] GDLY_RST = 8'h00;

    // Codes
    localparam logic [2:0] TRK_INTERNAL = 3'h4;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {FMT_TDM, FMT_LJ, FMT_I2S, FMT_RSVD} fmt_e;

endpackage : tdm_router_pkg

// ---- tdm_pin_sync.sv ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes each bit is a slow level against clk; no bus coherence.
`timescale 1ns/10ps
module tdm_pin_sync #(
    parameter int W = 1
) (
    // System
    input  wire logic         clk,
    input  wire logic         rst,
    // Pins
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= '0;
            q       <= '0;
        end
        else
        begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule : tdm_pin_sync

// ---- tdm_sample_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides and registered flags.
// Assumes producer and consumer share clk.
`timescale 1ns/10ps
module tdm_sample_fifo #(
    parameter int W     = 96,
    parameter int DEPTH = 16
) (
    // System
    input  wire logic         clk,
    input  wire logic         rst,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    end

    logic [W-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0]   cnt_ff;
    wire           push = in_valid && in_ready;
    wire           pop  = out_valid && out_ready;
    wire [AW:0]    nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign out_data = mem_ff[rd_ff];

    always_ff @(posedge clk)
    begin
        if (push) mem_ff[wr_ff] <= in_data;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ff     <= '0;
            rd_ff     <= '0;
            cnt_ff    <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end
        else
        begin
            wr_ff     <= wr_ff + AW'(push);
            rd_ff     <= rd_ff + AW'(pop);
            cnt_ff    <= nxt_cnt;
            in_ready  <= nxt_cnt < (AW+1)'(DEPTH);
            out_valid <= nxt_cnt != '0;
        end
    end
endmodule : tdm_sample_fifo

// ---- tdm_slot_router.sv ----
// TDM / left-justified / I2S slot router: ADC samples out, DAC paths in.
// Assumes a slave serial port whose bit clock is far slower than clk.
`timescale 1ns/10ps
// Function
// [R1] TDM: ADC samples fill slots one to four
// [R2] Chain up to four devices per frame
// [R3] Host sets chain bit to enable chaining
// [R4] PCM: inputs 1,2 primary; 3,4 secondary
// [R5] Audio DACs use selected four-slot group
// [R6] Codes 0-3 input a, 4-7 input b
// [R7] Low-latency path uses its own group select
// [R8] Tracking source field in port control register
// [R9] Tracking codes 0-3 low bytes; 5-7 reserved
// [R10] Tracking code 4 takes internal masked sample
// [R11] PCM: input a to DACs 1,2; b to 3,4
// [R12] Host powers tracking DAC down in PCM
// [R13] Host never routes one slot twice
// [R14] Low-latency added after group delay
// [R15] Audio path has programmable group delay
// [R16] Host drives two lines for 8-slot chains
// [R17] Every slot is 32 bit clocks
// [R18] Chain forwards input b four slots later
// [R19] Samples in upper 24 bits; tracking bytes MSB first
module tdm_slot_router
    import tdm_router_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int GD_DEPTH   = 8
) (
    // System
    input  wire logic                   clk,
    input  wire logic                   rst,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Serial pins
    input  wire logic                   serial_clk,
    input  wire logic                   frame_sync,
    input  wire logic                   serial_in_a,
    input  wire logic                   serial_in_b,
    output logic                        primary_serial_output,
    output logic                        secondary_serial_output,
    // ADC sample stream
    input  wire logic [SAMPLE_BITS-1:0] analog_in_1,
    input  wire logic [SAMPLE_BITS-1:0] analog_in_2,
    input  wire logic [SAMPLE_BITS-1:0] analog_in_3,
    input  wire logic [SAMPLE_BITS-1:0] analog_in_4,
    input  wire logic                   adc_valid,
    output logic                        adc_ready,
    // Tracking source from masking logic
    input  wire logic [SAMPLE_BITS-1:0] masked_track_in,
    // DAC samples
    output logic [SAMPLE_BITS-1:0]      audio_dac_1,
    output logic [SAMPLE_BITS-1:0]      audio_dac_2,
    output logic [SAMPLE_BITS-1:0]      audio_dac_3,
    output logic [SAMPLE_BITS-1:0]      audio_dac_4,
    output logic [SAMPLE_BITS-1:0]      tracking_dac,
    output logic                        sample_strobe
);
    localparam int GW = $clog2(GD_DEPTH);
    localparam int AW = CHANNELS * SAMPLE_BITS;

    initial
    begin
        if (GD_DEPTH < 2 || (1 << GW) != GD_DEPTH) $error("GD_DEPTH: power of two");
        if (FIFO_DEPTH < 2) $error("FIFO_DEPTH too small");
    end

    function automatic logic [CNT_W-1:0] wrap(input logic [CNT_W-1:0] c,
                                             input logic [CNT_W-1:0] last);
        wrap = (c == last) ? '0 : c + 1'b1;
    endfunction : wrap

    function automatic logic [SAMPLE_BITS-1:0] pick(input logic [2:0] code,
                                                   input logic [SLOT_BITS-1:0] wa,
                                                   input logic [SLOT_BITS-1:0] wb);
        pick = code[2] ? wb[SLOT_BITS-1:PAD_BITS] : wa[SLOT_BITS-1:PAD_BITS];
    endfunction : pick

    // Saturate so a loud low-latency signal cannot wrap the output
    function automatic logic [SAMPLE_BITS-1:0] sat_add(input logic [SAMPLE_BITS-1:0] a,
                                                      input logic [SAMPLE_BITS-1:0] b);
        logic [SAMPLE_BITS-1:0] s;
        s = a + b;
        if (a[SAMPLE_BITS-1] == b[SAMPLE_BITS-1] && s[SAMPLE_BITS-1] != a[SAMPLE_BITS-1])
            s = {a[SAMPLE_BITS-1], {(SAMPLE_BITS-1){~a[SAMPLE_BITS-1]}}};
        sat_add = s;
    endfunction : sat_add

    // Registers
    logic [7:0] ctrl_ff;
    logic [7:0] dsel_ff;
    logic [7:0] gdly_ff;
    logic [15:0] frame_cnt_ff;

    wire       chain_en = ctrl_ff[CHAIN_BIT];
    wire [2:0] trk_sel  = ctrl_ff[TRK_LSB +: 3];
    wire [2:0] dac_sel  = dsel_ff[DAC_LSB +: 3];
    wire [2:0] ll_sel   = dsel_ff[LL_LSB +: 3];
    wire [GW-1:0] gd_sel = gdly_ff[GD_LSB +: GW];
    wire [1:0] fmt_bits = ctrl_ff[FMT_LSB +: 2];
    wire       is_i2s   = fmt_bits == 2'(FMT_I2S);
    wire       is_tdm   = !is_i2s && fmt_bits != 2'(FMT_LJ);
    wire       trk_rsvd = trk_sel > TRK_INTERNAL;

    // Pin synchronisers
    logic [3:0] pins_s;
    tdm_pin_sync #(.W(4)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({serial_clk, frame_sync, serial_in_a, serial_in_b}),
        .q   (pins_s)
    );
    wire sclk_s = pins_s[3];
    wire fs_s   = pins_s[2];
    wire sa_s   = pins_s[1];
    wire sb_s   = pins_s[0];

    logic sclk_d_ff;
    logic fs_d_ff;
    wire  rise = sclk_s && !sclk_d_ff;
    wire  fall = !sclk_s && sclk_d_ff;
    wire  fs_edge = is_i2s ? (fs_d_ff && !fs_s) : (fs_s && !fs_d_ff);

    // Bit position in frame
    logic [CNT_W-1:0] cnt_ff;
    wire [CNT_W-1:0] last_idx = is_tdm ? LAST_TDM : LAST_PCM;
    wire [CNT_W-1:0] cur_idx  = fs_edge ? (is_i2s ? I2S_PRE : '0) : wrap(cnt_ff, last_idx);
    wire [3:0] cur_slot = cur_idx[CNT_W-1:5];
    wire [CNT_W-1:0] tx_idx = wrap(cnt_ff, last_idx);
    wire [3:0] tx_slot = tx_idx[CNT_W-1:5];
    wire [4:0] tx_bit  = tx_idx[4:0];
    wire word_done  = rise && cur_idx[4:0] == BIT_LAST;  // R17
    wire frame_done = word_done && cur_slot == (is_tdm ? SLOT_LAST_TDM : SLOT_LAST_PCM);

    logic [SLOT_BITS-1:0] rx_a_ff;
    logic [SLOT_BITS-1:0] rx_b_ff;
    wire  [SLOT_BITS-1:0] word_a = {rx_a_ff[SLOT_BITS-2:0], sa_s};
    wire  [SLOT_BITS-1:0] word_b = {rx_b_ff[SLOT_BITS-2:0], sb_s};

    // Received samples
    logic [SAMPLE_BITS-1:0] dac_rx_ff [CHANNELS];
    logic [SAMPLE_BITS-1:0] ll_rx_ff  [CHANNELS];
    logic [SAMPLE_BITS-1:0] trk_asm_ff;
    logic [SLOT_BITS-1:0]   chain_q_ff [CHANNELS];
    wire dac_hit = is_tdm && dac_sel[1:0] == cur_slot[3:2];  // R5 R6
    wire ll_hit  = is_tdm && ll_sel[1:0] == cur_slot[3:2];  // R7
    wire trk_hit = is_tdm && !trk_sel[2] && trk_sel[1:0] == cur_slot[3:2]
                   && cur_slot[1:0] != 2'h3;  // R9
    wire pcm_hit = !is_tdm && cur_slot <= SLOT_LAST_PCM;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sclk_d_ff <= 1'b0;
            fs_d_ff   <= 1'b0;
            cnt_ff    <= '0;
            rx_a_ff   <= '0;
            rx_b_ff   <= '0;
        end
        else
        begin
            sclk_d_ff <= sclk_s;
            if (rise)
            begin
                fs_d_ff <= fs_s;
                cnt_ff  <= cur_idx;
                rx_a_ff <= word_a;
                rx_b_ff <= word_b;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dac_rx_ff  <= '{default: '0};
            ll_rx_ff   <= '{default: '0};
            chain_q_ff <= '{default: '0};
            trk_asm_ff <= '0;
        end
        else if (word_done)
        begin
            if (dac_hit)
                dac_rx_ff[cur_slot[1:0]] <= pick(dac_sel, word_a, word_b);  // R5
            if (ll_hit)
                ll_rx_ff[cur_slot[1:0]] <= pick(ll_sel, word_a, word_b);  // R7
            if (trk_hit)
                trk_asm_ff[(2 - cur_slot[1:0]) * TRK_BYTE +: TRK_BYTE]
                    <= word_a[TRK_BYTE-1:0];  // R19
            if (pcm_hit)
            begin
                dac_rx_ff[{1'b0, cur_slot[0]}] <= word_a[SLOT_BITS-1:PAD_BITS];  // R11
                dac_rx_ff[{1'b1, cur_slot[0]}] <= word_b[SLOT_BITS-1:PAD_BITS];  // R11
                ll_rx_ff <= '{default: '0};
            end
            if (is_tdm)
                chain_q_ff <= {word_b, chain_q_ff[0:CHANNELS-2]};  // R18
        end
    end

    // ADC sample FIFO, drained one set per frame
    logic              fifo_valid;
    logic [AW-1:0]     fifo_data;
    logic [AW-1:0]     adc_hold_ff;
    tdm_sample_fifo #(.W(AW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (adc_valid),
        .in_ready  (adc_ready),
        .in_data   ({analog_in_4, analog_in_3, analog_in_2, analog_in_1}),
        .out_valid (fifo_valid),
        .out_ready (frame_done),
        .out_data  (fifo_data)
    );

    // Transmit words for the upcoming bit
    wire [SAMPLE_BITS-1:0] adc_pri = adc_hold_ff[tx_slot[1:0] * SAMPLE_BITS +: SAMPLE_BITS];
    wire [SAMPLE_BITS-1:0] adc_sec = adc_hold_ff[(tx_slot[1:0] + 2'h2) * SAMPLE_BITS
                                                 +: SAMPLE_BITS];
    wire [SLOT_BITS-1:0] tdm_word = (tx_slot < ADC_SLOTS) ? {adc_pri, PAD_BITS'(0)}  // R1
                                  : chain_en ? chain_q_ff[CHANNELS-1]  // R2 R3 R18
                                  : '0;
    wire [SLOT_BITS-1:0] pri_word = is_tdm ? tdm_word : {adc_pri, PAD_BITS'(0)};  // R4
    wire [SLOT_BITS-1:0] sec_word = is_tdm ? '0 : {adc_sec, PAD_BITS'(0)};  // R4 R19

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            primary_serial_output   <= 1'b0;
            secondary_serial_output <= 1'b0;
            adc_hold_ff             <= '0;
        end
        else
        begin
            if (fall)
            begin
                primary_serial_output   <= pri_word[BIT_LAST - tx_bit];
                secondary_serial_output <= sec_word[BIT_LAST - tx_bit];
            end
            if (frame_done && fifo_valid)
                adc_hold_ff <= fifo_data;
        end
    end

    // Group delay line; low-latency samples join after it
    logic [AW-1:0]   gd_mem_ff [GD_DEPTH];
    logic [GW-1:0]   gd_wr_ff;
    logic [SAMPLE_BITS-1:0] aud_ff [CHANNELS];
    wire  [AW-1:0]   dac_now = {dac_rx_ff[3], dac_rx_ff[2], dac_rx_ff[1], dac_rx_ff[0]};
    wire  [AW-1:0]   delayed = (gd_sel == '0) ? dac_now : gd_mem_ff[gd_wr_ff - gd_sel];  // R15

    always_ff @(posedge clk)
    begin
        if (frame_done) gd_mem_ff[gd_wr_ff] <= dac_now;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gd_wr_ff      <= '0;
            aud_ff        <= '{default: '0};
            tracking_dac  <= '0;
            sample_strobe <= 1'b0;
            frame_cnt_ff  <= '0;
        end
        else
        begin
            sample_strobe <= frame_done;
            if (frame_done)
            begin
                gd_wr_ff     <= gd_wr_ff + 1'b1;
                frame_cnt_ff <= frame_cnt_ff + 1'b1;
                for (int k = 0; k < CHANNELS; k++)
                    aud_ff[k] <= sat_add(delayed[k*SAMPLE_BITS +: SAMPLE_BITS],
                                         ll_rx_ff[k]);  // R14
                if (is_tdm && !trk_sel[2])
                    tracking_dac <= trk_asm_ff;  // R8 R9
                else if (is_tdm && trk_sel == TRK_INTERNAL)
                    tracking_dac <= masked_track_in;  // R10
            end
        end
    end

    assign audio_dac_1 = aud_ff[0];
    assign audio_dac_2 = aud_ff[1];
    assign audio_dac_3 = aud_ff[2];
    assign audio_dac_4 = aud_ff[3];

    // AXI4-Lite slave; one write and one read in flight
    logic              aw_held_ff;
    logic              w_held_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [31:0]       w_data_ff;
    logic [3:0]        w_strb_ff;
    wire  [ADDR_W-1:0] waddr = {aw_addr_ff[ADDR_W-1:2], 2'b00};
    wire  [ADDR_W-1:0] raddr = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    wire  do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
    wire  w_ok  = waddr == OFS_CTRL || waddr == OFS_DSEL || waddr == OFS_GDLY
                  || waddr == OFS_STAT;
    wire  wr_b0 = do_write && w_strb_ff[0];
    wire  ar_go = s_axi_arvalid && s_axi_arready;
    wire  [31:0] rd_mux = (raddr == OFS_CTRL) ? {24'h0, ctrl_ff}
                        : (raddr == OFS_DSEL) ? {24'h0, dsel_ff}
                        : (raddr == OFS_GDLY) ? {24'h0, gdly_ff}
                        : {15'h0, trk_rsvd, frame_cnt_ff};
    wire  r_ok = raddr == OFS_CTRL || raddr == OFS_DSEL || raddr == OFS_GDLY
                 || raddr == OFS_STAT;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff  <= '0;
            w_strb_ff  <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            ctrl_ff    <= CTRL_RST;
            dsel_ff    <= DSEL_RST;
            gdly_ff    <= GDLY_RST;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_ff   <= 1'b0;
                w_held_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_b0 && waddr == OFS_CTRL) ctrl_ff <= w_data_ff[7:0];  // R3
            if (wr_b0 && waddr == OFS_DSEL) dsel_ff <= w_data_ff[7:0];
            if (wr_b0 && waddr == OFS_GDLY) gdly_ff <= w_data_ff[7:0];
        end
    end

    // Ready flags are registered so the outputs come from flops
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held_ff && !(s_axi_wvalid && s_axi_wready);
            s_axi_arready <= !s_axi_rvalid && !ar_go;
            if (ar_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= r_ok ? rd_mux : '0;
                s_axi_rresp  <= r_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_adc_pad_zero: assert property ( // R1
        fall && is_tdm && tx_slot < ADC_SLOTS && tx_bit >= PAD_FIRST
        |=> !primary_serial_output) else $error("ADC slot padding not zero");
    chk_chain_off_zero: assert property ( // R3
        fall && is_tdm && !chain_en && tx_slot >= ADC_SLOTS
        |=> !primary_serial_output) else $error("Unchained slot not zero");
    chk_tdm_sec_idle: assert property ( // R4
        fall && is_tdm |=> !secondary_serial_output) else $error("Secondary active in TDM");
    chk_dac_group_load: assert property ( // R5
        word_done && dac_hit |=> dac_rx_ff[$past(cur_slot[1:0])]
        == $past(pick(dac_sel, word_a, word_b))) else $error("DAC slot group wrong");
    chk_trk_reserved: assert property ( // R9
        frame_done && trk_rsvd |=> $stable(tracking_dac)) else $error("Reserved code moved");
    chk_trk_internal: assert property ( // R10
        frame_done && is_tdm && trk_sel == TRK_INTERNAL
        |=> tracking_dac == $past(masked_track_in)) else $error("Internal tracking lost");
    chk_strobe_pulse: assert property ( // R14
        frame_done |=> sample_strobe ##1 !sample_strobe) else $error("Strobe not one cycle");
    chk_bresp_hold: assert property ( // R17
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped");
endmodule : tdm_slot_router

// ---- tdm_host_model.sv ----
// Serial host model: bit clock, frame sync and two data lines, plus capture.
// Assumes the router reads on rising edges and drives on falling edges.
`timescale 1ns/10ps
module tdm_host_model (
    // Link driven to the router
    output logic      serial_clk,
    output logic      frame_sync,
    output logic      serial_in_a,
    output logic      serial_in_b,
    // Router outputs
    input  wire logic primary_serial_output,
    input  wire logic secondary_serial_output
);
    int          nbits = 512;
    int          b;
    logic [31:0] wa;
    logic [31:0] wb;
    logic [31:0] cap [2][16];

    // Frames back to back, so the bit clock never idles
    initial
    begin
        serial_clk = 1'b0;
        forever
        begin
            for (b = 0; b < nbits; b++)
            begin
                wa = {16'h0000, 4'h1, 4'(b / 32), 4'h5, 4'(b / 32)};
                wb = {16'h0000, 4'h2, 4'(b / 32), 4'h6, 4'(b / 32)};
                serial_clk = 1'b0;
                frame_sync = (b < nbits / 2);
                serial_in_a = wa[31 - b % 32];
                serial_in_b = wb[31 - b % 32];
                #400;
                serial_clk = 1'b1;
                cap[0][b / 32][31 - b % 32] = primary_serial_output;
                cap[1][b / 32][31 - b % 32] = secondary_serial_output;
                #400;
            end
        end
    end
endmodule : tdm_host_model

// ---- tdm_slot_router_tb.sv ----
// Bench for the slot router: register bus tasks, routing and serial checks.
// Assumes the host model runs the link; ADC inputs stay constant.
`timescale 1ns/10ps
module tdm_slot_router_tb
    import tdm_router_pkg::*;
;
    logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, adc_valid;
    logic adc_ready, sample_strobe, serial_clk, frame_sync, serial_in_a, serial_in_b;
    logic primary_serial_output, secondary_serial_output;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [23:0] analog_in_1, analog_in_2, analog_in_3, analog_in_4, masked_track_in;
    logic [23:0] audio_dac_1, audio_dac_2, audio_dac_3, audio_dac_4, tracking_dac;
    int err_total, cmp_count;

    tdm_slot_router tdm_slot_router_i (.*);
    tdm_host_model tdm_host_model_i (.*);

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bready <= 1'b0;
                chk("bresp", er, s_axi_bresp);
            end
        end
        while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rready <= 1'b0;
                chk("rdata", exp, s_axi_rdata);
                chk("rresp", er, s_axi_rresp);
            end
        end
        while (s_axi_arvalid || s_axi_rready);
    endtask : rd

    function automatic logic [23:0] smp(input logic [2:0] g, input logic [1:0] i);
        return {16'h0000, g[2] ? 4'h2 : 4'h1, g[1:0], i};
    endfunction : smp

    task automatic results;
        $display("Mismatches %0d, comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Whole run is about 70k cycles
    initial
    begin
        #9000000;
        err_total++;
        results();
    end

    initial
    begin
        logic [2:0] g;
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, adc_valid} = 49'h0;
        s_axi_wstrb = 4'hF;
        {analog_in_1, analog_in_2} = 48'hA11111_A22222;
        {analog_in_3, analog_in_4} = 48'hA33333_A44444;
        masked_track_in = 24'h5A5A5A;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_CTRL, 32'h0, RESP_OKAY);
        rd(8'h10, 32'h0, RESP_SLVERR);
        wr(8'h10, 32'h1, RESP_SLVERR);
        adc_valid <= 1'b1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk("adc_ready", 32'h0, adc_ready);
        for (int c = 0; c < 8; c++)
        begin
            g = 3'(c);
            wr(OFS_DSEL, {24'h0, 1'b0, g ^ 3'h1, 1'b0, g}, RESP_OKAY);
            wr(OFS_CTRL, {24'h0, 4'h0, g, g[0]}, RESP_OKAY);
            repeat (2) @(posedge sample_strobe);
            @(negedge clk);
            chk("dac1", smp(g, 0) + smp(g ^ 3'h1, 0), audio_dac_1);
            chk("dac2", smp(g, 1) + smp(g ^ 3'h1, 1), audio_dac_2);
            chk("dac3", smp(g, 2) + smp(g ^ 3'h1, 2), audio_dac_3);
            chk("dac4", smp(g, 3) + smp(g ^ 3'h1, 3), audio_dac_4);
            chk("track", g > 3 ? masked_track_in : {4'h5, g[1:0], 2'h0, 4'h5, g[1:0], 2'h1,
                4'h5, g[1:0], 2'h2}, tracking_dac);
            chk("slot1", analog_in_1, tdm_host_model_i.cap[0][0][31:8]);
            chk("slot4", analog_in_4, tdm_host_model_i.cap[0][3][31:8]);
            chk("slot5", g[0] ? smp(3'h4, 0) : 24'h0, tdm_host_model_i.cap[0][4][31:8]);
            chk("slot16", g[0] ? smp(3'h6, 3) : 24'h0, tdm_host_model_i.cap[0][15][31:8]);
        end
        wr(OFS_CTRL, 32'h10, RESP_OKAY);
        tdm_host_model_i.nbits = 64;
        repeat (4) @(posedge sample_strobe);
        @(negedge clk);
        chk("lj dac1", smp(3'h0, 0), audio_dac_1);
        chk("lj dac2", smp(3'h0, 1), audio_dac_2);
        chk("lj dac3", smp(3'h4, 0), audio_dac_3);
        chk("lj dac4", smp(3'h4, 1), audio_dac_4);
        chk("lj p0", analog_in_1, tdm_host_model_i.cap[0][0][31:8]);
        chk("lj p1", analog_in_2, tdm_host_model_i.cap[0][1][31:8]);
        chk("lj s0", analog_in_3, tdm_host_model_i.cap[1][0][31:8]);
        chk("lj s1", analog_in_4, tdm_host_model_i.cap[1][1][31:8]);
        chk("lj track", masked_track_in, tracking_dac);
        results();
    end
endmodule : tdm_slot_router_tb
